//--- design/zero_cross_event_logic.sv
// zero-cross detector logic: register slave, interrupt flag and enables
// assumes an AXI4-Lite master on aclk and an async sink/source level from the pad
//
// Contract
// - pin above crossing reference means sink active, below means source active
// - with polarity clear, output status reads 1 for sink, 0 for source
// - polarity_invert set inverts output status: 1 means source active
// - polarity inversion acts on output status even when detector disabled
// - separate rising and falling edge detectors on the polarity-adjusted output
// - either detector firing with its enable set sets zero_cross_irq_flag
// - rise_irq_enable gates rising, fall_irq_enable gates falling; both in control reg
// - changing polarity may cause a flag-setting edge regardless of enable
// - an enabled edge in the clearing cycle leaves the flag set
// - edge detection and flag setting keep running in sleep
// - fuse clear: detector on from power-on; fuse set: software enables it
`include "zcd_consts.svh"

module zero_cross_event_logic
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // ********************************
   // AXI4-Lite slave
   // ********************************
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // ********************************
   // pad side and system
   // ********************************
   input  wire logic        sink_active_raw,
   input  wire logic        zero_cross_default_off_fuse,
   output logic             detector_enable,
   output logic             irq
);

   zcd_pkg::top_state_t q;
   zcd_pkg::top_state_t d;
   edge_if              ev ();

   logic wr_go;
   logic rd_go;
   logic rd_flag;

   // ********************************
   // decode helpers
   // ********************************
   // one decoder shared by read and write so both agree on the map
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == `ZC_OFF_CTRL) || (a == `ZC_OFF_FLAG)
               || (a == `ZC_OFF_IEN)  || (a == `ZC_OFF_ICON);
   endfunction

   function automatic logic [7:0] read_value(input logic [7:0] a,
                                             input zcd_pkg::top_state_t s,
                                             input logic out_lvl);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         `ZC_OFF_CTRL:
         begin
            v[`ZC_BIT_EN]   = s.en;
            v[`ZC_BIT_OUT]  = out_lvl;
            v[`ZC_BIT_POL]  = s.polarity_invert;
            v[`ZC_BIT_RISE] = s.rise_en;
            v[`ZC_BIT_FALL] = s.fall_en;
         end
         `ZC_OFF_FLAG: v[`ZC_BIT_FLAG] = s.flag;
         `ZC_OFF_IEN:  v[`ZC_BIT_IE]   = s.ie;
         `ZC_OFF_ICON:
         begin
            v[`ZC_BIT_GIE]  = s.global_irq_enable;
            v[`ZC_BIT_PERIPHERAL_IRQ_GLOBAL_ENABLE] = s.peripheral_irq_global_enable;
         end
         default: v = 8'h00;
      endcase
      read_value = v;
   endfunction

   // ********************************
   // edge unit
   // ********************************
   zc_edge_unit u_edge
   (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .sink_active_raw (sink_active_raw),
      .ev              (ev.unit)
   );

   assign ev.polarity_invert     = q.polarity_invert;
   assign ev.rise_en = q.rise_en;
   assign ev.fall_en = q.fall_en;

   // ********************************
   // bus handshakes
   // ********************************
   // a write is applied once both halves are held and no response is pending
   assign wr_go   = q.aw_full && q.w_full && !q.bvalid;
   assign rd_go   = s_axi_arvalid && !q.rvalid;
   assign rd_flag = rd_go && (s_axi_araddr == `ZC_OFF_FLAG);

   // ********************************
   // next state
   // ********************************
   always_comb
   begin
      d = q;
      // address and data taken in either order
      if (s_axi_awvalid && !q.aw_full)
      begin
         d.aw_full = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_full)
      begin
         d.w_full = 1'b1;
         d.wdata  = s_axi_wdata[7:0];
         d.wstrb0 = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready)
         d.bvalid = 1'b0;
      if (q.rvalid && s_axi_rready)
         d.rvalid = 1'b0;

      // register writes; only lane 0 holds bits, others are ignored
      if (wr_go)
      begin
         d.aw_full = 1'b0;
         d.w_full  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = is_mapped(q.aw_addr) ? `AXI_OKAY : `AXI_DECERR;
         if (q.wstrb0)
         begin
            unique case (q.aw_addr)
               `ZC_OFF_CTRL:
               begin
                  d.en      = q.wdata[`ZC_BIT_EN];
                  d.polarity_invert     = q.wdata[`ZC_BIT_POL];
                  d.rise_en = q.wdata[`ZC_BIT_RISE];
                  d.fall_en = q.wdata[`ZC_BIT_FALL];
               end
               `ZC_OFF_FLAG: d.flag = q.wdata[`ZC_BIT_FLAG];
               `ZC_OFF_IEN:  d.ie   = q.wdata[`ZC_BIT_IE];
               `ZC_OFF_ICON:
               begin
                  d.global_irq_enable  = q.wdata[`ZC_BIT_GIE];
                  d.peripheral_irq_global_enable = q.wdata[`ZC_BIT_PERIPHERAL_IRQ_GLOBAL_ENABLE];
               end
               default: d.en = q.en;
            endcase
         end
      end

      // reads: status shows the live polarity-adjusted level
      if (rd_go)
      begin
         d.rvalid = 1'b1;
         d.rdata  = read_value(s_axi_araddr, q, ev.out_level);
         d.rresp  = is_mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_DECERR;
      end
      // reading the flag register clears the sticky flag
      if (rd_flag)
         d.flag = 1'b0;
      // set wins over any clear in the same cycle; runs whatever the enable
      if (ev.set_pulse)
         d.flag = 1'b1;

      // power-on default from the fuse, taken after it is synchronised
      d.fs1 = zero_cross_default_off_fuse;
      d.fs2 = q.fs1;
      if (q.boot != `ZC_BOOT_DONE)
         d.boot = q.boot + 2'h1;
      if (q.boot == `ZC_BOOT_LOAD)
         d.en = ~q.fs2;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         q <= '0;
      else
         q <= d;
   end

   // ********************************
   // outputs
   // ********************************
   assign s_axi_awready   = !q.aw_full;
   assign s_axi_wready    = !q.w_full;
   assign s_axi_bvalid    = q.bvalid;
   assign s_axi_bresp     = q.bresp;
   assign s_axi_arready   = !q.rvalid;
   assign s_axi_rvalid    = q.rvalid;
   assign s_axi_rresp     = q.rresp;
   assign s_axi_rdata     = {24'h000000, q.rdata};
   assign detector_enable = q.en;
   // one level line; all three enables must be set by software
   assign irq             = q.flag && q.ie && q.peripheral_irq_global_enable && q.global_irq_enable;

   // ********************************
   // checks
   // ********************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_flag_on_edge: assert property (
      ev.set_pulse |=> q.flag ##1 1'b1)
      else $error("edge event did not set flag");
   a_set_beats_clear: assert property (
      (ev.set_pulse && (rd_flag || (wr_go && q.aw_addr == `ZC_OFF_FLAG))) |=> q.flag)
      else $error("clear won over a same-cycle edge");
   a_flag_sticky: assert property (
      (q.flag && !rd_flag && !(wr_go && q.aw_addr == `ZC_OFF_FLAG)) |=> q.flag)
      else $error("flag dropped without software");
   a_fuse_default: assert property (
      (q.boot == `ZC_BOOT_LOAD) |=> detector_enable == !$past(q.fs2))
      else $error("power-on enable does not follow fuse");
   a_status_read: assert property (
      (rd_go && s_axi_araddr == `ZC_OFF_CTRL) |=>
         s_axi_rvalid && s_axi_rdata[`ZC_BIT_OUT] == $past(ev.out_level))
      else $error("status bit read back wrong");
   a_irq_level: assert property (
      (irq && !rd_flag && !wr_go) |=> irq)
      else $error("interrupt line dropped on its own");

   // ********************************
   // checks on software access
   // ********************************
   // control fields land together; the enable may lose to the power-on load
   a_ctrl_write: assert property (
      (wr_go && q.wstrb0 && q.aw_addr == `ZC_OFF_CTRL) |=>
         q.polarity_invert == $past(q.wdata[`ZC_BIT_POL])
         && q.rise_en == $past(q.wdata[`ZC_BIT_RISE])
         && q.fall_en == $past(q.wdata[`ZC_BIT_FALL]))
      else $error("control write did not land");
   a_enable_write: assert property (
      (wr_go && q.wstrb0 && q.aw_addr == `ZC_OFF_CTRL && q.boot != `ZC_BOOT_LOAD) |=>
         detector_enable == $past(q.wdata[`ZC_BIT_EN]))
      else $error("software enable write was lost");
   // after the power-on load only software moves the enable
   a_enable_held: assert property (
      (q.boot == `ZC_BOOT_DONE && !wr_go) |=> $stable(detector_enable))
      else $error("enable moved without a write");
   // lane 0 off or an unmapped address: answered, nothing changes
   a_strobe_off: assert property (
      (wr_go && !q.wstrb0) |=>
         $stable({q.polarity_invert, q.rise_en, q.fall_en, q.ie, q.global_irq_enable, q.peripheral_irq_global_enable}))
      else $error("write without lane 0 changed a register");
   a_unmapped_write: assert property (
      (wr_go && !is_mapped(q.aw_addr)) |=> s_axi_bresp == `AXI_DECERR
         && $stable({q.polarity_invert, q.rise_en, q.fall_en, q.ie, q.global_irq_enable, q.peripheral_irq_global_enable}))
      else $error("unmapped write was not refused");
   a_unmapped_read: assert property (
      (rd_go && !is_mapped(s_axi_araddr)) |=>
         s_axi_rresp == `AXI_DECERR && s_axi_rdata == 32'h00000000)
      else $error("unmapped read was not refused");
   // the three interrupt enables are plain software bits
   a_line_enable_write: assert property (
      (wr_go && q.wstrb0 && q.aw_addr == `ZC_OFF_IEN) |=>
         q.ie == $past(q.wdata[`ZC_BIT_IE]))
      else $error("interrupt enable write did not land");
   a_irq_enables_write: assert property (
      (wr_go && q.wstrb0 && q.aw_addr == `ZC_OFF_ICON) |=>
         q.global_irq_enable == $past(q.wdata[`ZC_BIT_GIE]) && q.peripheral_irq_global_enable == $past(q.wdata[`ZC_BIT_PERIPHERAL_IRQ_GLOBAL_ENABLE]))
      else $error("interrupt control write did not land");

   // ********************************
   // checks on the flag and the line
   // ********************************
   // software load of the flag, unless an edge or a read shares the cycle
   a_flag_write: assert property (
      (wr_go && q.wstrb0 && q.aw_addr == `ZC_OFF_FLAG && !ev.set_pulse && !rd_flag) |=>
         q.flag == $past(q.wdata[`ZC_BIT_FLAG]))
      else $error("flag write did not land");
   // the read returns the flag as it stood, then clears it
   a_read_preclear: assert property (
      rd_flag |=> s_axi_rdata[`ZC_BIT_FLAG] == $past(q.flag))
      else $error("flag read did not return the old flag");
   a_read_clears: assert property (
      (rd_flag && !ev.set_pulse) |=> !q.flag)
      else $error("flag read did not clear the flag");
   // a fresh event reaches the line one cycle later when every enable stands
   a_irq_raised: assert property (
      (ev.set_pulse && q.ie && q.peripheral_irq_global_enable && q.global_irq_enable && !wr_go) |=> irq)
      else $error("enabled event did not raise the line");

endmodule // zero_cross_event_logic

//--- design/zcd_consts.svh
// offsets, field positions, counter values and codes of the zero-cross block
// assumes inclusion by bare name from the design files of this block and from the bench
`ifndef ZCD_CONSTS_SVH
`define ZCD_CONSTS_SVH

// ********************************
// register byte addresses
// ********************************
`define ZC_OFF_CTRL   8'h00
`define ZC_OFF_FLAG   8'h04
`define ZC_OFF_IEN    8'h08
`define ZC_OFF_ICON   8'h0C

// ********************************
// field positions
// ********************************
`define ZC_BIT_EN     3'h7
`define ZC_BIT_OUT    3'h5
`define ZC_BIT_POL    3'h4
`define ZC_BIT_RISE   3'h1
`define ZC_BIT_FALL   3'h0
`define ZC_BIT_FLAG   3'h6
`define ZC_BIT_IE     3'h6
`define ZC_BIT_GIE    3'h7
`define ZC_BIT_PERIPHERAL_IRQ_GLOBAL_ENABLE   3'h6

// ********************************
// codes and counts
// ********************************
`define AXI_OKAY      2'h0
`define AXI_DECERR    2'h3
`define ZC_BOOT_LOAD  2'h2
`define ZC_BOOT_DONE  2'h3
`define ZC_WARM_DONE  2'h3

`endif

//--- design/zcd_pkg.sv
// state types of the zero-cross block
// assumes the constants header supplies all numbers
package zcd_pkg;

   // edge unit: synchroniser, level and edge pulse
   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       lvl;
      logic       set;
      logic [1:0] warm;
   } unit_state_t;

   // top: bus slave and registers
   typedef struct packed {
      logic       aw_full;
      logic [7:0] aw_addr;
      logic       w_full;
      logic [7:0] wdata;
      logic       wstrb0;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic       en;
      logic       polarity_invert;
      logic       rise_en;
      logic       fall_en;
      logic       flag;
      logic       ie;
      logic       global_irq_enable;
      logic       peripheral_irq_global_enable;
      logic       fs1;
      logic       fs2;
      logic [1:0] boot;
   } top_state_t;

endpackage

//--- design/edge_if.sv
// carrier between register logic and the edge unit
// assumes both ends run on aclk
interface edge_if;
   logic polarity_invert;
   logic rise_en;
   logic fall_en;
   logic out_level;
   logic set_pulse;

   modport ctrl (output polarity_invert, output rise_en, output fall_en,
                 input out_level, input set_pulse);
   modport unit (input polarity_invert, input rise_en, input fall_en,
                 output out_level, output set_pulse);
endinterface

//--- design/zc_edge_unit.sv
// synchroniser, polarity and edge detectors of the zero-cross block
// assumes sink_active_raw comes asynchronously from the analog front end
`include "zcd_consts.svh"

module zc_edge_unit
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic sink_active_raw,
   edge_if.unit      ev
);

   zcd_pkg::unit_state_t q;
   zcd_pkg::unit_state_t d;

   // ********************************
   // next state
   // ********************************
   // level is formed from s2 and the polarity bit; s1 feeds nothing but s2
   always_comb
   begin
      d      = q;
      d.s1   = sink_active_raw;
      d.s2   = q.s1;
      d.lvl  = q.s2 ^ ev.polarity_invert;
      d.set  = 1'b0;
      if (q.warm != `ZC_WARM_DONE)
         d.warm = q.warm + 2'h1;
      // no edge until the previous level is real, so reset gives no spurious event
      if (q.warm == `ZC_WARM_DONE)
         d.set = (ev.rise_en & d.lvl & ~q.lvl)
               | (ev.fall_en & ~d.lvl & q.lvl);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         q <= '0;
      else
         q <= d;
   end

   assign ev.out_level = q.lvl;
   assign ev.set_pulse = q.set;

   // ********************************
   // checks
   // ********************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_level_path: assert property (
      (q.warm == `ZC_WARM_DONE) |-> q.lvl == ($past(sink_active_raw, 3) ^ $past(ev.polarity_invert)))
      else $error("level does not follow synchronised pin and polarity");
   a_rise_gated: assert property (
      (q.set && q.lvl) |-> $past(ev.rise_en) && !$past(q.lvl))
      else $error("rising event without enable or edge");
   a_fall_gated: assert property (
      (q.set && !q.lvl) |-> $past(ev.fall_en) && $past(q.lvl))
      else $error("falling event without enable or edge");
   a_edge_fires: assert property (
      ($past(q.warm) == `ZC_WARM_DONE && q.lvl != $past(q.lvl)
       && $past(ev.rise_en) && $past(ev.fall_en)) |-> q.set)
      else $error("enabled edge did not fire");

endmodule // zc_edge_unit

//--- bench/ac_source.sv
// behavioural pin side: ac waveform reaching the pad through the series resistor
// assumes the bench sets the pin voltage in millivolts after aclk edges
module ac_source
#(
   parameter int REF_MV = 750
)
(
   input  wire logic [11:0] pin_mv,
   output logic             sink_active_raw
);
   timeunit 1ns;
   timeprecision 1ps;

   // sink above the crossing reference, source below; the pad is unclocked
   assign sink_active_raw = pin_mv > 12'(REF_MV);
endmodule // ac_source

//--- bench/tb.sv
// self-checking bench of the zero-cross event logic over its register bus
// assumes the design constants header and the ac_source pin model
`include "zcd_consts.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   logic        sink_active_raw;
   logic        zero_cross_default_off_fuse = 1'b1;
   logic        detector_enable;
   logic        irq;
   logic [11:0] pin_mv = 12'h064;
   logic [3:0]  strb = 4'hF;
   int          err_count = 0;
   int          n_checks = 0;

   // 100 MHz system clock
   always #5 aclk = ~aclk;

   zero_cross_event_logic i_dut
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .sink_active_raw, .zero_cross_default_off_fuse, .detector_enable, .irq
   );

   ac_source i_src
   (
      .pin_mv,
      .sink_active_raw
   );

   // ********************************
   // bus and pin tasks
   // ********************************
   task automatic summarize();
      if (err_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // both channels offered together; bready held until the response
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int   n;
      logic ad;
      logic wd;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_wstrb   <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      for (n = 0; n < 100; n++)
      begin
         @(posedge aclk);
         if (s_axi_bvalid === 1'b1 && ad && wd)
            break;
         if (s_axi_awready === 1'b1 && !ad)
         begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1 && !wd)
         begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b0;
      if (n == 100)
      begin
         err_count++;
         summarize();
      end
      `CHK(s_axi_bresp, er)
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      int   n;
      logic ad;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      ad = 1'b0;
      for (n = 0; n < 100; n++)
      begin
         @(posedge aclk);
         if (s_axi_rvalid === 1'b1 && ad)
            break;
         if (s_axi_arready === 1'b1 && !ad)
         begin
            ad = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
      end
      s_axi_rready <= 1'b0;
      if (n == 100)
      begin
         err_count++;
         summarize();
      end
      `CHK(s_axi_rdata, {24'h000000, ed})
      `CHK(s_axi_rresp, er)
   endtask

   // pad change, then time for synchroniser and edge pulse to land
   task automatic pin(input logic [11:0] mv);
      @(posedge aclk);
      pin_mv <= mv;
      tick(4);
   endtask

   task automatic rst(input logic f);
      @(posedge aclk);
      aresetn <= 1'b0;
      zero_cross_default_off_fuse <= f;
      tick(6);
      aresetn <= 1'b1;
      tick(5);
   endtask

   // ********************************
   // scenarios
   // ********************************
   initial
   begin
      rst(1'b1);
      `CHK(detector_enable, 1'b0)
      rd(`ZC_OFF_CTRL, 8'h00, `AXI_OKAY);
      rd(`ZC_OFF_FLAG, 8'h00, `AXI_OKAY);
      rd(`ZC_OFF_IEN, 8'h00, `AXI_OKAY);
      rd(`ZC_OFF_ICON, 8'h00, `AXI_OKAY);
      rd(8'h10, 8'h00, `AXI_DECERR);
      wr(8'h10, 8'hFF, `AXI_DECERR);
      wr(`ZC_OFF_CTRL, 8'h80, `AXI_OKAY);
      `CHK(detector_enable, 1'b1)
      pin(12'd1200);
      rd(`ZC_OFF_CTRL, 8'hA0, `AXI_OKAY);
      // module off, polarity on: out must still follow the inversion
      wr(`ZC_OFF_CTRL, 8'h10, `AXI_OKAY);
      tick(4);
      rd(`ZC_OFF_CTRL, 8'h10, `AXI_OKAY);
      rd(`ZC_OFF_FLAG, 8'h00, `AXI_OKAY);
      wr(`ZC_OFF_CTRL, 8'h02, `AXI_OKAY);
      tick(4);
      rd(`ZC_OFF_FLAG, 8'h40, `AXI_OKAY);
      rd(`ZC_OFF_FLAG, 8'h00, `AXI_OKAY);
      pin(12'd100);
      rd(`ZC_OFF_FLAG, 8'h00, `AXI_OKAY);
      pin(12'd1200);
      rd(`ZC_OFF_FLAG, 8'h40, `AXI_OKAY);
      wr(`ZC_OFF_CTRL, 8'h01, `AXI_OKAY);
      pin(12'd100);
      rd(`ZC_OFF_FLAG, 8'h40, `AXI_OKAY);
      pin(12'd1200);
      rd(`ZC_OFF_FLAG, 8'h00, `AXI_OKAY);
      pin(12'd100);
      // interrupt needs all three enables on top of the flag
      `CHK(irq, 1'b0)
      wr(`ZC_OFF_IEN, 8'h40, `AXI_OKAY);
      `CHK(irq, 1'b0)
      wr(`ZC_OFF_ICON, 8'h80, `AXI_OKAY);
      `CHK(irq, 1'b0)
      wr(`ZC_OFF_ICON, 8'hC0, `AXI_OKAY);
      tick(2);
      `CHK(irq, 1'b1)
      tick(50);
      `CHK(irq, 1'b1)
      wr(`ZC_OFF_FLAG, 8'h00, `AXI_OKAY);
      tick(2);
      `CHK(irq, 1'b0)
      // rising edge timed to land on the clearing write
      wr(`ZC_OFF_CTRL, 8'h03, `AXI_OKAY);
      @(posedge aclk);
      pin_mv <= 12'd1200;
      @(posedge aclk);
      wr(`ZC_OFF_FLAG, 8'h00, `AXI_OKAY);
      rd(`ZC_OFF_FLAG, 8'h40, `AXI_OKAY);
      // falling edge with every enable up reaches the line
      pin(12'd100);
      tick(1);
      `CHK(irq, 1'b1)
      rst(1'b0);
      `CHK(detector_enable, 1'b1)
      rd(`ZC_OFF_CTRL, 8'h80, `AXI_OKAY);
      // lane 0 strobe off: answered, nothing changes
      strb = 4'hE;
      wr(`ZC_OFF_CTRL, 8'h13, `AXI_OKAY);
      strb = 4'hF;
      rd(`ZC_OFF_CTRL, 8'h80, `AXI_OKAY);
      summarize();
   end
endmodule // tb
